// ===== fcs_host.sv
// Host controller that sequences commands into the flash command register
`timescale 1ns/1ps
module fcs_host #(
    parameter int ERASE_CYCLES = fcs_pkg::ERASE_CYC,
    parameter int PROG_CYCLES  = fcs_pkg::PROG_CYC,
    parameter int RECOV_CYCLES = fcs_pkg::RECOV_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire fcs_pkg::fcs_req_t          req,
    output logic                            rsp_valid,
    output logic [fcs_pkg::DATA_W-1:0]      rsp_data,
    output fcs_pkg::fcs_pins_t              pins,
    output logic [fcs_pkg::DATA_W-1:0]      data_lines_o,
    output logic                            data_lines_oe,
    input  wire logic [fcs_pkg::DATA_W-1:0] data_lines_i
);
    typedef enum logic [2:0] {
        S_IDLE, S_WLOW, S_WHIGH, S_WAIT, S_RLOW, S_DONE
    } fcs_state_t;

    fcs_state_t        state_q;
    fcs_pkg::fcs_req_t cur_q;
    logic [1:0]        cyc_q;     // Write cycle index within command
    logic [1:0]        ncyc_q;    // Write cycles this command needs
    logic [23:0]       cnt_q;
    logic [7:0]        rd_q;

    assign req_ready = (state_q == S_IDLE);

    // Byte on the bus for a given write cycle
    function automatic logic [7:0] wr_byte(input fcs_pkg::fcs_req_t r, input logic [1:0] c);
        logic [7:0] b;
        b = fcs_pkg::CMD_READ;
        case (r.op)
            fcs_pkg::OP_READ:            b = fcs_pkg::CMD_READ;
            fcs_pkg::OP_SIG_READ:        b = fcs_pkg::CMD_SIG;
            fcs_pkg::OP_ERASE:           b = fcs_pkg::CMD_ERASE;
            fcs_pkg::OP_ERASE_VERIFY:    b = fcs_pkg::CMD_ERASE_VF;
            fcs_pkg::OP_PROGRAM:         b = (c == 2'd0) ? fcs_pkg::CMD_PROG : r.data;
            fcs_pkg::OP_PROGRAM_VERIFY:  b = fcs_pkg::CMD_PROG_VF;
            fcs_pkg::OP_ABORT:           b = fcs_pkg::CMD_RESET;
            default:                     b = fcs_pkg::CMD_READ;
        endcase
        return b;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= S_IDLE;
            cur_q   <= '0;
            cyc_q   <= 2'd0;
            ncyc_q  <= 2'd0;
            cnt_q   <= 24'h000000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (req_valid) begin
                        cur_q <= req;
                        cyc_q <= 2'd0;
                        cnt_q <= 24'h000000;
                        case (req.op)
                            fcs_pkg::OP_HV_SIG_READ: begin
                                ncyc_q  <= 2'd0;
                                state_q <= S_RLOW;
                            end
                            fcs_pkg::OP_ERASE, fcs_pkg::OP_PROGRAM,
                            fcs_pkg::OP_ABORT: begin
                                ncyc_q  <= 2'd2;
                                state_q <= S_WLOW;
                            end
                            default: begin
                                ncyc_q  <= 2'd1;
                                state_q <= S_WLOW;
                            end
                        endcase
                    end
                end
                S_WLOW: begin
                    // Device takes address on this falling edge
                    if (cnt_q == 24'(fcs_pkg::WP_CYC - 1)) begin
                        cnt_q   <= 24'h000000;
                        state_q <= S_WHIGH;
                    end else begin
                        cnt_q <= cnt_q + 24'd1;
                    end
                end
                S_WHIGH: begin
                    if (cnt_q == 24'(fcs_pkg::WPH_CYC - 1)) begin
                        cnt_q <= 24'h000000;
                        if (cyc_q + 2'd1 < ncyc_q) begin
                            cyc_q   <= cyc_q + 2'd1;
                            state_q <= S_WLOW;
                        end else begin
                            state_q <= S_WAIT;
                        end
                    end else begin
                        cnt_q <= cnt_q + 24'd1;
                    end
                end
                S_WAIT: begin
                    // Pulse length timed here by the host counter; host waits the
                    // minimum, then the next write ends the pulse
                    if ((cur_q.op == fcs_pkg::OP_ERASE &&
                         cnt_q == 24'(ERASE_CYCLES - 1)) ||
                        (cur_q.op == fcs_pkg::OP_PROGRAM &&
                         cnt_q == 24'(PROG_CYCLES - 1)) ||
                        (cur_q.op == fcs_pkg::OP_ERASE_VERIFY &&
                         cnt_q == 24'(RECOV_CYCLES - 1)) ||
                        (cur_q.op == fcs_pkg::OP_PROGRAM_VERIFY &&
                         cnt_q == 24'(RECOV_CYCLES - 1)) ||
                        (cur_q.op == fcs_pkg::OP_READ) ||
                        (cur_q.op == fcs_pkg::OP_SIG_READ) ||
                        (cur_q.op == fcs_pkg::OP_ABORT)) begin
                        cnt_q <= 24'h000000;
                        if (cur_q.op == fcs_pkg::OP_ERASE ||
                            cur_q.op == fcs_pkg::OP_PROGRAM ||
                            cur_q.op == fcs_pkg::OP_ABORT) begin
                            state_q <= S_DONE;
                        end else begin
                            state_q <= S_RLOW;
                        end
                    end else begin
                        cnt_q <= cnt_q + 24'd1;
                    end
                end
                S_RLOW: begin
                    if (cnt_q == 24'(fcs_pkg::ACC_CYC - 1)) begin
                        cnt_q   <= 24'h000000;
                        state_q <= S_DONE;
                    end else begin
                        cnt_q <= cnt_q + 24'd1;
                    end
                end
                S_DONE:  state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Read data captured at the end of the access window
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_q <= 8'h00;
        end else if (state_q == S_RLOW && cnt_q == 24'(fcs_pkg::ACC_CYC - 1)) begin
            rd_q <= data_lines_i;
        end
    end

    // Strobes and buses, registered from the state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins          <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, vpp_hi: 1'b0,
                               hv_line9: 1'b0, addr: '0};
            data_lines_o  <= 8'h00;
            data_lines_oe <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_data      <= 8'h00;
        end else begin
            rsp_valid    <= (state_q == S_DONE);
            rsp_data     <= rd_q;
            pins.vpp_hi  <= (cur_q.op != fcs_pkg::OP_HV_SIG_READ);
            pins.we_n    <= !(state_q == S_WLOW);
            pins.oe_n    <= !(state_q == S_RLOW);
            pins.ce_n    <= (state_q == S_IDLE || state_q == S_DONE);
            pins.hv_line9 <= (state_q == S_RLOW &&
                              cur_q.op == fcs_pkg::OP_HV_SIG_READ);
            if (cur_q.op == fcs_pkg::OP_HV_SIG_READ) begin
                pins.addr <= {16'h0000, cur_q.addr[0]};
            end else if (cur_q.op == fcs_pkg::OP_PROGRAM && cyc_q == 2'd0) begin
                pins.addr <= '0;
            end else begin
                pins.addr <= cur_q.addr;
            end
            data_lines_o  <= wr_byte(cur_q, cyc_q);
            data_lines_oe <= (state_q == S_WLOW || state_q == S_WHIGH);
        end
    end

    a_we_only_writes: assert property (@(posedge clk_sys) disable iff (rst)
        !pins.we_n |-> (pins.oe_n && !pins.ce_n && data_lines_oe))
        else $error("write strobe without proper bus state");
    // Write strobes finished in this command, counted at the pins so the
    // check does not lean on the sequencer's own cycle bookkeeping
    logic       we_prev_q;
    logic [1:0] we_rise_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            we_prev_q <= 1'b1;
            we_rise_q <= 2'd0;
        end else begin
            we_prev_q <= pins.we_n;
            if (state_q == S_IDLE) begin
                we_rise_q <= 2'd0;
            end else if (pins.we_n && !we_prev_q && we_rise_q != 2'd3) begin
                we_rise_q <= we_rise_q + 2'd1;
            end
        end
    end

    a_erase_two_cmds: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == S_WAIT && cur_q.op == fcs_pkg::OP_ERASE) |-> we_rise_q == 2'd2)
        else $error("erase started without two writes");
    a_hv_sig_addr: assert property (@(posedge clk_sys) disable iff (rst)
        pins.hv_line9 |-> (pins.addr[16:1] == 16'h0000 && !pins.oe_n && pins.we_n))
        else $error("high voltage signature with bad address");
    a_idle_standby: assert property (@(posedge clk_sys) disable iff (rst)
        $past(state_q == S_IDLE) && state_q == S_IDLE |-> pins.ce_n)
        else $error("chip select low while idle");
    a_no_oe_drive: assert property (@(posedge clk_sys) disable iff (rst)
        !pins.oe_n |-> !data_lines_oe)
        else $error("bus contention on data lines");
    a_abort_data: assert property (@(posedge clk_sys) disable iff (rst)
        (!pins.we_n && cur_q.op == fcs_pkg::OP_ABORT) |-> data_lines_o == 8'hFF)
        else $error("abort without reset byte");
    a_prog_first: assert property (@(posedge clk_sys) disable iff (rst)
        ($fell(pins.we_n) && cur_q.op == fcs_pkg::OP_PROGRAM && cyc_q == 2'd0)
        |-> data_lines_o == 8'h40)
        else $error("program without setup byte");
    a_rsp_after_done: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == S_DONE) |=> rsp_valid ##1 !rsp_valid)
        else $error("response pulse wrong");
endmodule // fcs_host

// ===== fcs_pkg.sv
// Package for the flash command sequencer host controller
package fcs_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam logic [7:0] CMD_READ     = 8'h00;
    localparam logic [7:0] CMD_SIG      = 8'h90;
    localparam logic [7:0] CMD_ERASE    = 8'h20;
    localparam logic [7:0] CMD_ERASE_VF = 8'hA0;
    localparam logic [7:0] CMD_PROG     = 8'h40;
    localparam logic [7:0] CMD_PROG_VF  = 8'hC0;
    localparam logic [7:0] CMD_RESET    = 8'hFF;
    localparam logic [16:0] SIG_MAKER_ADDR = 17'h00000;
    localparam logic [16:0] SIG_PART_ADDR  = 17'h00001;
    localparam int CLK_NS        = 10;
    localparam int T_WP_NS       = 40;
    localparam int T_WPH_NS      = 20;
    localparam int T_PROG_NS     = 10000;
    localparam int T_ERASE_NS    = 9500000;
    localparam int T_RECOV_NS    = 6000;
    localparam int T_ACC_NS      = 90;
    localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_CYC  = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOV_CYC = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
    typedef enum logic [2:0] {
        OP_READ, OP_SIG_READ, OP_HV_SIG_READ, OP_ERASE, OP_ERASE_VERIFY,
        OP_PROGRAM, OP_PROGRAM_VERIFY, OP_ABORT
    } fcs_op_t;
    typedef struct packed {
        fcs_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } fcs_req_t;
    typedef struct packed {
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                vpp_hi;
        logic                hv_line9;
        logic [ADDR_W-1:0]   addr;
    } fcs_pins_t;
endpackage

// ===== fcs_flash_model.sv
// Behavioural model of the flash device that the host controller drives
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_ID  = 8'hC3  // Arbitrary value
) (
    input  wire fcs_pkg::fcs_pins_t pins,
    input  wire logic [7:0]         dq_in,
    output logic [7:0]              dq_out,
    output logic                    dq_oe
);
    logic [7:0]  mem [256];
    logic [7:0]  cmd_q  = fcs_pkg::CMD_READ;
    logic [7:0]  prev_q = 8'h01;
    logic        arm_q  = 1'b0;
    logic [16:0] tmp_q  = '0;
    logic [16:0] alat_q = '0;
    logic        rd;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // Falling strobe address is only committed by commands that use it
    always @(negedge pins.we_n) if (!pins.ce_n) tmp_q = pins.addr;
    always @(posedge pins.we_n) begin
        // Low programming supply blocks any change, ramps included
        if (!pins.ce_n && pins.vpp_hi) begin
            if (arm_q) begin
                mem[tmp_q[7:0]] = mem[tmp_q[7:0]] & dq_in;
                alat_q = tmp_q;
                arm_q = 1'b0;
                prev_q = 8'h01;
            end else begin
                case (dq_in)
                    fcs_pkg::CMD_READ, fcs_pkg::CMD_SIG: cmd_q = dq_in;
                    fcs_pkg::CMD_PROG_VF: cmd_q = dq_in;
                    fcs_pkg::CMD_ERASE: begin
                        // Only a second 20H in a row clears the array
                        if (prev_q == fcs_pkg::CMD_ERASE) begin
                            foreach (mem[i]) mem[i] = 8'hFF;
                        end
                        cmd_q = dq_in;
                    end
                    fcs_pkg::CMD_ERASE_VF: begin
                        cmd_q = dq_in;
                        alat_q = tmp_q;
                    end
                    fcs_pkg::CMD_PROG: arm_q = 1'b1;
                    fcs_pkg::CMD_RESET: if (prev_q == dq_in) cmd_q = fcs_pkg::CMD_READ;
                    default: ;
                endcase
                prev_q = dq_in;
            end
        end
    end
    assign rd = !pins.ce_n && !pins.oe_n && pins.we_n;
    assign dq_oe = rd;
    assign dq_out = pins.hv_line9 ? (pins.addr[0] ? PART_ID : MAKER_ID)
        : (cmd_q == fcs_pkg::CMD_SIG) ? (pins.addr[0] ? PART_ID : MAKER_ID)
        : (cmd_q == fcs_pkg::CMD_ERASE_VF || cmd_q == fcs_pkg::CMD_PROG_VF)
        ? mem[alat_q[7:0]] : mem[pins.addr[7:0]];
endmodule // fcs_flash_model

// ===== testbench.sv
// Self-checking bench for the flash command sequencer host
`timescale 1ns/1ps
module testbench;
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic               req_valid = 1'b0;
    logic               req_ready;
    fcs_pkg::fcs_req_t  req = '0;
    logic               rsp_valid;
    logic [7:0]         rsp_data;
    fcs_pkg::fcs_pins_t pins;
    logic [7:0]         host_dq;
    logic               host_oe;
    logic [7:0]         dev_dq;
    logic               dev_oe;
    logic [7:0]         bus;
    logic               idle_q = 1'b0;
    logic [7:0]         got;
    int                 n_mismatch = 0;
    int                 comparisons = 0;
    always #5 clk_sys = ~clk_sys;
    // Floating bus changes every cycle so stale data never looks valid
    always @(posedge clk_sys) idle_q <= ~idle_q;
    assign bus = dev_oe ? dev_dq : host_oe ? host_dq : ({8{idle_q}} ^ 8'h5A);
    fcs_host #(.ERASE_CYCLES(20), .PROG_CYCLES(10), .RECOV_CYCLES(5)) dut (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
        .data_lines_o(host_dq), .data_lines_oe(host_oe), .data_lines_i(bus));
    fcs_flash_model flash (.pins(pins), .dq_in(bus), .dq_out(dev_dq), .dq_oe(dev_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run_op(input fcs_pkg::fcs_op_t op, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1) @(negedge clk_sys);
        req_valid = 1'b1;
        req = '{op: op, addr: a, data: d};
        @(negedge clk_sys);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            n_mismatch++;
            $display("BAD t=%0t no answer", $time);
        end
        got = rsp_data;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // High voltage on line nine only with the other lines low and strobe high
    always @(negedge clk_sys) begin
        if (pins.hv_line9 === 1'b1 && !pins.ce_n) begin
            check({7'h00, pins.addr[16:1] == 16'h0000 && pins.we_n}, 8'h01);
        end
    end
    task automatic t_idle();
        check({6'h00, pins.ce_n, pins.we_n}, 8'h03);
        check({6'h00, host_oe, dev_oe}, 8'h00);
        run_op(fcs_pkg::OP_READ, 17'h00012, 8'h00);
        check(got, 8'hFF);
        $display("test idle done");
    endtask
    task automatic t_sig();
        run_op(fcs_pkg::OP_SIG_READ, fcs_pkg::SIG_MAKER_ADDR, 8'h00);
        check(got, 8'h5A);
        run_op(fcs_pkg::OP_SIG_READ, fcs_pkg::SIG_PART_ADDR, 8'h00);
        check(got, 8'hC3);
        run_op(fcs_pkg::OP_HV_SIG_READ, fcs_pkg::SIG_MAKER_ADDR, 8'h00);
        check(got, 8'h5A);
        run_op(fcs_pkg::OP_HV_SIG_READ, fcs_pkg::SIG_PART_ADDR, 8'h00);
        check(got, 8'hC3);
        $display("test signature done");
    endtask
    task automatic t_prog();
        run_op(fcs_pkg::OP_PROGRAM, 17'h00012, 8'h3C);
        run_op(fcs_pkg::OP_PROGRAM_VERIFY, 17'h00000, 8'h00);
        check(got, 8'h3C);
        run_op(fcs_pkg::OP_PROGRAM, 17'h00013, 8'hA5);
        run_op(fcs_pkg::OP_ABORT, 17'h00000, 8'h00);
        // Verify mode was active; the second FFH write of the abort brings read mode back here
        check(flash.cmd_q, fcs_pkg::CMD_READ);
        run_op(fcs_pkg::OP_READ, 17'h00013, 8'h00);
        check(got, 8'hA5);
        run_op(fcs_pkg::OP_READ, 17'h00012, 8'h00);
        check(got, 8'h3C);
        $display("test program done");
    endtask
    task automatic t_erase();
        run_op(fcs_pkg::OP_ERASE, 17'h00000, 8'h00);
        for (int i = 0; i < 256; i++) begin
            run_op(fcs_pkg::OP_ERASE_VERIFY, 17'(i), 8'h00);
            check(got, 8'hFF);
        end
        run_op(fcs_pkg::OP_READ, 17'h00012, 8'h00);
        check(got, 8'hFF);
        $display("test erase done");
    endtask
    initial begin
        #200_000;
        n_mismatch++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_idle();
        t_sig();
        t_prog();
        t_erase();
        give_verdict();
    end
endmodule // testbench
